// ### src/seqrb_bank.sv
`timescale 1ns/1ps
module seqrb_bank
#(
  parameter logic [7:0] MODEL_ID    = 8'h5A, // Arbitrary identity value
  parameter logic [7:0] REVISION_ID = 8'h11  // Arbitrary identity value
)
(
  // Clock and reset
  input  logic                   clk_in,
  input  logic                   rst_n_in,
  // Register access from the serial engine
  input  seqrb_pkg::seqrb_req_s  req_in,
  output logic [7:0]             rd_data_out,
  output logic                   rd_valid_out,
  output logic                   wr_refused_out,
  // Engine status and events
  input  seqrb_pkg::seqrb_stat_s stat_in,
  input  logic [7:0]             fault1_set_in,
  input  logic [7:0]             fault2_set_in,
  input  logic [7:0]             vendor_set_in,
  input  logic                   wdt_force_in,
  input  logic [1:0]             wdt_pdmd_in,
  input  logic                   pseq_force_act_in,
  // Non-volatile image load
  input  seqrb_pkg::seqrb_nvm_s  nvm_in,
  input  logic                   nvm_load_in,
  // Configuration towards the engines
  output logic [7:0]             general_output_levels_out,
  output logic [7:0]             debounce_out,
  output logic [7:0]             long_press_out,
  output logic [1:0]             forced_shutdown_code_out,
  output logic                   force_act_out,
  output logic                   force_int_out,
  output logic [7:0]             ctl2_out,
  output logic                   packet_check_enable_out,
  output logic                   packet_check_required_out,
  output logic                   reject_missing_pec_out,
  output logic                   watchdog_sleep_disable_out,
  output logic [7:0]             wdt_close_out,
  output logic [7:0]             wdt_open_out,
  output logic [6:0]             locks_out,
  output logic [7:0]             vendor_flags_out
);
  import seqrb_pkg::*;

  // Stored registers
  logic [7:0] alt_en_ff;
  logic [7:0] alt_dir_ff;
  logic [7:0] pp_up_ff;
  logic [7:0] pp_lo_ff;
  logic [7:0] clk_cfg_ff;
  logic [7:0] general_output_levels_ff;
  logic [7:0] debounce_ff;
  logic [7:0] long_prs_ff;
  logic [7:0] ctl1_ff;
  logic [7:0] ctl2_ff;
  logic [7:0] wdt_cfg_ff;
  logic [7:0] wdt_close_ff;
  logic [7:0] wdt_open_ff;
  logic [6:0] locks_ff;
  logic [7:0] rd_data_ff;
  logic       rd_valid_ff;
  logic       wr_refused_ff;
  logic [7:0] nxt_ctl1_ff;
  logic [6:0] nxt_locks_ff;
  logic [7:0] nxt_rd_data_ff;

  // Sticky fault flags
  logic [7:0] fault1_flags;
  logic [7:0] fault2_flags;
  logic [7:0] vendor_flags;

  // Address decode
  wire [7:0] a          = req_in.addr;
  wire [7:0] d          = req_in.data;
  wire       hit_gp     = (a == ADDR_GENERAL_OUTPUT_LEVELS);
  wire       hit_deb    = (a == ADDR_DEBOUNCE);
  wire       hit_lp     = (a == ADDR_LONG_PRS);
  wire       hit_ctl1   = (a == ADDR_CTL1);
  wire       hit_ctl2   = (a == ADDR_CTL2);
  wire       hit_wcfg   = (a == ADDR_WDT_CFG);
  wire       hit_wclose = (a == ADDR_WDT_CLOSE);
  wire       hit_wopen  = (a == ADDR_WDT_OPEN);
  wire       hit_prot   = (a == ADDR_PROT);

  // Group membership of each lockable register
  wire grp_wrk = hit_gp | hit_ctl1;
  wire grp_ctl = hit_deb | hit_lp | hit_ctl2;
  wire grp_wdt = hit_wcfg | hit_wclose | hit_wopen;

  // A locked group refuses the write whole, without touching any bit
  wire lock_hit = (grp_wrk & locks_ff[LOCK_WRK])
                | (grp_ctl & locks_ff[LOCK_CTL])
                | (grp_wdt & locks_ff[LOCK_WDT]);
  wire wr_ok    = req_in.wr & ~lock_hit;

  // Per-register write strobes
  wire we_gp     = wr_ok & hit_gp;
  wire we_deb    = wr_ok & hit_deb;
  wire we_lp     = wr_ok & hit_lp;
  wire we_ctl1   = wr_ok & hit_ctl1;
  wire we_ctl2   = wr_ok & hit_ctl2;
  wire we_wcfg   = wr_ok & hit_wcfg;
  wire we_wclose = wr_ok & hit_wclose;
  wire we_wopen  = wr_ok & hit_wopen;
  wire we_prot   = req_in.wr & hit_prot;

  // Fault flag registers; hardware set wins over the host clear
  seqrb_w1c_flags #(.W(8)) u_fault1
  (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .set_in      (fault1_set_in),
    .clr_wr_in   (req_in.wr & (a == ADDR_FAULT1)),
    .clr_data_in (d),
    .flags_out   (fault1_flags)
  );

  seqrb_w1c_flags #(.W(8)) u_fault2
  (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .set_in      (fault2_set_in),
    .clr_wr_in   (req_in.wr & (a == ADDR_FAULT2)),
    .clr_data_in (d),
    .flags_out   (fault2_flags)
  );

  seqrb_w1c_flags #(.W(8)) u_vendor
  (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .set_in      (vendor_set_in),
    .clr_wr_in   (req_in.wr & (a == ADDR_VENDOR)),
    .clr_data_in (d),
    .flags_out   (vendor_flags)
  );

  // Control byte: watchdog shutdown outranks the host, engine sets force-active
  wire [1:0] shdn_host = we_ctl1 ? d[CTL1_SHDN_LSB +: 2] : ctl1_ff[CTL1_SHDN_LSB +: 2];
  wire [1:0] shdn_nxt  = wdt_force_in ? wdt_pdmd_in : shdn_host;
  wire       fact_clr  = we_ctl1 & ~d[CTL1_FACT_BIT];
  wire       fact_nxt  = pseq_force_act_in | (ctl1_ff[CTL1_FACT_BIT] & ~fact_clr);
  wire       fint_nxt  = we_ctl1 ? d[CTL1_FINT_BIT] : ctl1_ff[CTL1_FINT_BIT];
  assign nxt_ctl1_ff = {4'h0, fint_nxt, fact_nxt, shdn_nxt} & MASK_CTL1;

  // Locks only ever accumulate ones; zeros written are ignored
  assign nxt_locks_ff = locks_ff | (we_prot ? d[6:0] : RST_LOCKS);

  // Read selection; unmapped offsets return zero
  always_comb
  begin
    unique case (a)
      ADDR_MODEL:     nxt_rd_data_ff = MODEL_ID;
      ADDR_REVISION:  nxt_rd_data_ff = REVISION_ID;
      ADDR_FAULT1:    nxt_rd_data_ff = fault1_flags;
      ADDR_FAULT2:    nxt_rd_data_ff = fault2_flags;
      ADDR_VENDOR:    nxt_rd_data_ff = vendor_flags;
      ADDR_CONTROL_STATUS:  nxt_rd_data_ff = stat_in.control_status;
      ADDR_EN_A_UP:   nxt_rd_data_ff = stat_in.en_a_up;
      ADDR_EN_A_LO:   nxt_rd_data_ff = stat_in.en_a_lo;
      ADDR_EN_B_UP:   nxt_rd_data_ff = stat_in.en_b_up;
      ADDR_EN_B_LO:   nxt_rd_data_ff = stat_in.en_b_lo;
      ADDR_WATCHDOG_STATUS:  nxt_rd_data_ff = stat_in.watchdog_status;
      ADDR_TEST_STAT: nxt_rd_data_ff = stat_in.test_stat;
      ADDR_LAST_RST:  nxt_rd_data_ff = stat_in.last_rst;
      ADDR_ALT_EN:    nxt_rd_data_ff = alt_en_ff;
      ADDR_ALT_DIR:   nxt_rd_data_ff = alt_dir_ff;
      ADDR_PP_UP:     nxt_rd_data_ff = pp_up_ff;
      ADDR_PP_LO:     nxt_rd_data_ff = pp_lo_ff;
      ADDR_CLK_CFG:   nxt_rd_data_ff = clk_cfg_ff;
      ADDR_GENERAL_OUTPUT_LEVELS:    nxt_rd_data_ff = general_output_levels_ff;
      ADDR_DEBOUNCE:  nxt_rd_data_ff = debounce_ff;
      ADDR_LONG_PRS:  nxt_rd_data_ff = long_prs_ff;
      ADDR_CTL1:      nxt_rd_data_ff = ctl1_ff;
      ADDR_CTL2:      nxt_rd_data_ff = ctl2_ff;
      ADDR_WDT_CFG:   nxt_rd_data_ff = wdt_cfg_ff;
      ADDR_WDT_CLOSE: nxt_rd_data_ff = wdt_close_ff;
      ADDR_WDT_OPEN:  nxt_rd_data_ff = wdt_open_ff;
      ADDR_PROT:      nxt_rd_data_ff = {1'b0, locks_ff};
      default:        nxt_rd_data_ff = RST_BYTE;
    endcase
  end

  // Read-only configuration follows the non-volatile image only
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      alt_en_ff  <= RST_BYTE;
      alt_dir_ff <= RST_BYTE;
      pp_up_ff   <= RST_BYTE;
      pp_lo_ff   <= RST_BYTE;
      clk_cfg_ff <= RST_BYTE;
    end
    else if (nvm_load_in)
    begin
      alt_en_ff  <= nvm_in.alt_en;
      alt_dir_ff <= nvm_in.alt_dir;
      pp_up_ff   <= nvm_in.pp_up;
      pp_lo_ff   <= nvm_in.pp_lo;
      clk_cfg_ff <= nvm_in.clk_cfg;
    end
  end

  // Working and control group; the image load overrides a host write
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      general_output_levels_ff   <= RST_BYTE;
      debounce_ff <= RST_BYTE;
      long_prs_ff <= RST_BYTE;
      ctl1_ff     <= RST_BYTE;
      ctl2_ff     <= RST_BYTE;
    end
    else if (nvm_load_in)
    begin
      general_output_levels_ff   <= nvm_in.general_output_levels & MASK_GENERAL_OUTPUT_LEVELS;
      debounce_ff <= nvm_in.debounce & MASK_DEBOUNCE;
      long_prs_ff <= nvm_in.long_prs;
      ctl1_ff     <= nvm_in.ctl1 & MASK_CTL1;
      ctl2_ff     <= nvm_in.ctl2;
    end
    else
    begin
      general_output_levels_ff   <= we_gp ? (d & MASK_GENERAL_OUTPUT_LEVELS) : general_output_levels_ff;
      debounce_ff <= we_deb ? (d & MASK_DEBOUNCE) : debounce_ff;
      long_prs_ff <= we_lp ? d : long_prs_ff;
      ctl1_ff     <= nxt_ctl1_ff;
      ctl2_ff     <= we_ctl2 ? d : ctl2_ff;
    end
  end

  // Watchdog group
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wdt_cfg_ff   <= RST_BYTE;
      wdt_close_ff <= RST_BYTE;
      wdt_open_ff  <= RST_BYTE;
    end
    else if (nvm_load_in)
    begin
      wdt_cfg_ff   <= nvm_in.wdt_cfg & MASK_WDT_CFG;
      wdt_close_ff <= nvm_in.wdt_close;
      wdt_open_ff  <= nvm_in.wdt_open;
    end
    else
    begin
      wdt_cfg_ff   <= we_wcfg ? (d & MASK_WDT_CFG) : wdt_cfg_ff;
      wdt_close_ff <= we_wclose ? d : wdt_close_ff;
      wdt_open_ff  <= we_wopen ? d : wdt_open_ff;
    end
  end

  // Locks, and the registered answer to each access
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      locks_ff      <= RST_LOCKS;
      rd_data_ff    <= RST_BYTE;
      rd_valid_ff   <= 1'b0;
      wr_refused_ff <= 1'b0;
    end
    else
    begin
      locks_ff      <= nxt_locks_ff;
      rd_data_ff    <= req_in.rd ? nxt_rd_data_ff : rd_data_ff;
      rd_valid_ff   <= req_in.rd;
      wr_refused_ff <= req_in.wr & lock_hit;
    end
  end

  // Outputs; the lock vector gates the sequencing and clock groups outside
  assign rd_data_out                = rd_data_ff;
  assign rd_valid_out               = rd_valid_ff;
  assign wr_refused_out             = wr_refused_ff;
  assign general_output_levels_out                 = general_output_levels_ff;
  assign debounce_out               = debounce_ff;
  assign long_press_out             = long_prs_ff;
  assign forced_shutdown_code_out   = ctl1_ff[CTL1_SHDN_LSB +: 2];
  assign force_act_out              = ctl1_ff[CTL1_FACT_BIT];
  assign force_int_out              = ctl1_ff[CTL1_FINT_BIT];
  assign ctl2_out                   = ctl2_ff;
  assign packet_check_enable_out    = ctl2_ff[CTL2_PEC_EN];
  assign packet_check_required_out  = ctl2_ff[CTL2_PEC_REQ];
  assign reject_missing_pec_out     = ctl2_ff[CTL2_PEC_EN] & ctl2_ff[CTL2_PEC_REQ];
  assign watchdog_sleep_disable_out = wdt_cfg_ff[WDT_SLP_BIT];
  assign wdt_close_out              = wdt_close_ff;
  assign wdt_open_out               = wdt_open_ff;
  assign locks_out                  = locks_ff;
  assign vendor_flags_out           = vendor_flags;

  // Checks
  property p_sleep_bit;
    @(posedge clk_in) disable iff (!rst_n_in)
      (we_wcfg && !nvm_load_in) |=> (watchdog_sleep_disable_out == $past(d[WDT_SLP_BIT]));
  endproperty
  a_sleep_bit: assert property (p_sleep_bit) else $error("sleep bit not stored");

  property p_close_win;
    @(posedge clk_in) disable iff (!rst_n_in)
      (we_wclose && !nvm_load_in) |=> (wdt_close_out == $past(d));
  endproperty
  a_close_win: assert property (p_close_win) else $error("close window not stored");

  property p_open_win;
    @(posedge clk_in) disable iff (!rst_n_in)
      (we_wopen && !nvm_load_in) |=> (wdt_open_out == $past(d));
  endproperty
  a_open_win: assert property (p_open_win) else $error("open window not stored");

  property p_wrk_block;
    @(posedge clk_in) disable iff (!rst_n_in)
      (req_in.wr && hit_gp && locks_ff[LOCK_WRK] && !nvm_load_in) |=> ($stable(general_output_levels_out) && wr_refused_out);
  endproperty
  a_wrk_block: assert property (p_wrk_block) else $error("locked working write taken");

  property p_sleep_sequence_lock_set;
    @(posedge clk_in) disable iff (!rst_n_in)
      (we_prot && d[LOCK_SLEEP_SEQUENCE_LOCK]) |=> locks_out[LOCK_SLEEP_SEQUENCE_LOCK] [*2];
  endproperty
  a_sleep_sequence_lock_set: assert property (p_sleep_sequence_lock_set) else $error("sleep lock not set");

  property p_power_sequence_lock_set;
    @(posedge clk_in) disable iff (!rst_n_in)
      (we_prot && d[LOCK_POWER_SEQUENCE_LOCK]) |=> locks_out[LOCK_POWER_SEQUENCE_LOCK];
  endproperty
  a_power_sequence_lock_set: assert property (p_power_sequence_lock_set) else $error("power lock not set");

  property p_sequence_timing_lock_set;
    @(posedge clk_in) disable iff (!rst_n_in)
      (we_prot && d[LOCK_SEQUENCE_TIMING_LOCK]) |=> locks_out[LOCK_SEQUENCE_TIMING_LOCK];
  endproperty
  a_sequence_timing_lock_set: assert property (p_sequence_timing_lock_set) else $error("timing lock not set");

  property p_wdt_block;
    @(posedge clk_in) disable iff (!rst_n_in)
      (req_in.wr && hit_wclose && locks_ff[LOCK_WDT] && !nvm_load_in) |=> $stable(wdt_close_out);
  endproperty
  a_wdt_block: assert property (p_wdt_block) else $error("locked watchdog write taken");

  property p_vendor_clr;
    @(posedge clk_in) disable iff (!rst_n_in)
      (req_in.wr && (a == ADDR_VENDOR) && (vendor_set_in == RST_BYTE)) |=> ((vendor_flags & $past(d)) == RST_BYTE);
  endproperty
  a_vendor_clr: assert property (p_vendor_clr) else $error("vendor flag not cleared");

  property p_wdt_shdn;
    @(posedge clk_in) disable iff (!rst_n_in)
      (wdt_force_in && !nvm_load_in) |=> (forced_shutdown_code_out == $past(wdt_pdmd_in));
  endproperty
  a_wdt_shdn: assert property (p_wdt_shdn) else $error("watchdog shutdown code lost");

  property p_pec_cfg;
    @(posedge clk_in) disable iff (!rst_n_in)
      (we_ctl2 && !nvm_load_in) |=> (reject_missing_pec_out == ($past(d[CTL2_PEC_EN]) && $past(d[CTL2_PEC_REQ])));
  endproperty
  a_pec_cfg: assert property (p_pec_cfg) else $error("packet check config wrong");

  property p_lock_sticky;
    @(posedge clk_in) disable iff (!rst_n_in)
      ((locks_out & $past(locks_out)) == $past(locks_out)) && ($past(we_prot) || (locks_out == $past(locks_out)));
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit fell");

endmodule : seqrb_bank

// ### src/seqrb_pkg.sv
package seqrb_pkg;

  // Register offsets of the bank
  localparam logic [7:0] ADDR_MODEL     = 8'h00;
  localparam logic [7:0] ADDR_REVISION  = 8'h01;
  localparam logic [7:0] ADDR_FAULT1    = 8'h10;
  localparam logic [7:0] ADDR_FAULT2    = 8'h11;
  localparam logic [7:0] ADDR_VENDOR    = 8'h12;
  localparam logic [7:0] ADDR_CONTROL_STATUS  = 8'h13;
  localparam logic [7:0] ADDR_EN_A_UP   = 8'h14;
  localparam logic [7:0] ADDR_EN_A_LO   = 8'h15;
  localparam logic [7:0] ADDR_EN_B_UP   = 8'h16;
  localparam logic [7:0] ADDR_EN_B_LO   = 8'h17;
  localparam logic [7:0] ADDR_WATCHDOG_STATUS  = 8'h18;
  localparam logic [7:0] ADDR_TEST_STAT = 8'h19;
  localparam logic [7:0] ADDR_LAST_RST  = 8'h1A;
  localparam logic [7:0] ADDR_ALT_EN    = 8'h20;
  localparam logic [7:0] ADDR_ALT_DIR   = 8'h21;
  localparam logic [7:0] ADDR_PP_UP     = 8'h22;
  localparam logic [7:0] ADDR_PP_LO     = 8'h23;
  localparam logic [7:0] ADDR_CLK_CFG   = 8'h24;
  localparam logic [7:0] ADDR_GENERAL_OUTPUT_LEVELS    = 8'h25;
  localparam logic [7:0] ADDR_DEBOUNCE  = 8'h26;
  localparam logic [7:0] ADDR_LONG_PRS  = 8'h27;
  localparam logic [7:0] ADDR_CTL1      = 8'h28;
  localparam logic [7:0] ADDR_CTL2      = 8'h29;
  localparam logic [7:0] ADDR_WDT_CFG   = 8'h2C;
  localparam logic [7:0] ADDR_WDT_CLOSE = 8'h2D;
  localparam logic [7:0] ADDR_WDT_OPEN  = 8'h2E;
  localparam logic [7:0] ADDR_PROT      = 8'h2F;

  // Reset values and writable-bit masks
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [7:0] MASK_GENERAL_OUTPUT_LEVELS    = 8'h0F;
  localparam logic [7:0] MASK_DEBOUNCE  = 8'hFE;
  localparam logic [7:0] MASK_CTL1      = 8'h0F;
  localparam logic [7:0] MASK_WDT_CFG   = 8'h01;
  localparam logic [6:0] RST_LOCKS      = 7'h00;

  // Field positions
  localparam int CTL1_SHDN_LSB  = 0;
  localparam int CTL1_FACT_BIT  = 2;
  localparam int CTL1_FINT_BIT  = 3;
  localparam int CTL2_PEC_EN    = 0;
  localparam int CTL2_PEC_REQ   = 1;
  localparam int WDT_SLP_BIT    = 0;
  localparam int LOCK_WRK       = 0;
  localparam int LOCK_SLEEP_SEQUENCE_LOCK      = 1;
  localparam int LOCK_POWER_SEQUENCE_LOCK      = 2;
  localparam int LOCK_SEQUENCE_TIMING_LOCK      = 3;
  localparam int LOCK_WDT       = 4;
  localparam int LOCK_RTC       = 5;
  localparam int LOCK_CTL       = 6;
  localparam int NUM_LOCKS      = 7;

  // Watchdog window range in ms, as coded by the 8-bit fields
  localparam int WDT_WIN_MIN_MS = 1;
  localparam int WDT_WIN_MAX_MS = 864;

  // Register access request from the serial engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] data;
  } seqrb_req_s;

  // Live status from the sequencer, watchdog and test engines
  typedef struct packed {
    logic [7:0] control_status;
    logic [7:0] en_a_up;
    logic [7:0] en_a_lo;
    logic [7:0] en_b_up;
    logic [7:0] en_b_lo;
    logic [7:0] watchdog_status;
    logic [7:0] test_stat;
    logic [7:0] last_rst;
  } seqrb_stat_s;

  // Image loaded from non-volatile memory
  typedef struct packed {
    logic [7:0] alt_en;
    logic [7:0] alt_dir;
    logic [7:0] pp_up;
    logic [7:0] pp_lo;
    logic [7:0] clk_cfg;
    logic [7:0] general_output_levels;
    logic [7:0] debounce;
    logic [7:0] long_prs;
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic [7:0] wdt_cfg;
    logic [7:0] wdt_close;
    logic [7:0] wdt_open;
  } seqrb_nvm_s;

endpackage : seqrb_pkg

// ### src/seqrb_w1c_flags.sv
`timescale 1ns/1ps
module seqrb_w1c_flags
#(
  parameter int W = 8
)
(
  // Clock and reset
  input  logic         clk_in,
  input  logic         rst_n_in,
  // Hardware events and host clear
  input  logic [W-1:0] set_in,
  input  logic         clr_wr_in,
  input  logic [W-1:0] clr_data_in,
  // Sticky flags
  output logic [W-1:0] flags_out
);
  import seqrb_pkg::*;

  logic [W-1:0] flags_ff;
  logic [W-1:0] clr_mask;
  logic [W-1:0] nxt_flags_ff;

  // A set arriving with its clear wins so no event is lost
  assign clr_mask     = clr_wr_in ? clr_data_in : '0;
  assign nxt_flags_ff = (flags_ff & ~clr_mask) | set_in;
  assign flags_out    = flags_ff;

  // Flag storage
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      flags_ff <= '0;
    else
      flags_ff <= nxt_flags_ff;
  end

  property p_set_wins;
    @(posedge clk_in) disable iff (!rst_n_in)
      (set_in != '0) |=> ((flags_ff & $past(set_in)) == $past(set_in));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("flag event lost");

endmodule : seqrb_w1c_flags

// ### test/seqrb_host.sv
`timescale 1ns/1ps
// Host controller model: one byte access per request
module seqrb_host
  import seqrb_pkg::*;
(
  // Clock
  input  logic                  clk_in,
  // Read answer
  input  logic [7:0]            rd_data_in,
  input  logic                  rd_valid_in,
  // Request
  output seqrb_pkg::seqrb_req_s req_out
);
  initial req_out = '0;

  // Only this side ever raises lock bits
  // Clock time goes before alarm; those registers lie beyond this bank
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    req_out = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
    @(negedge clk_in);
    req_out = '0;
  endtask : wr

  // Answer is taken at the negedge after the accepting edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge clk_in);
    req_out = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
    @(negedge clk_in);
    req_out = '0;
    d = rd_data_in;
    v = rd_valid_in;
  endtask : rd
endmodule : seqrb_host

// ### test/testbench.sv
`timescale 1ns/1ps
module testbench;
  import seqrb_pkg::*;
  logic        clk_in, rst_n_in, rval, refused, wforce, pforce, nload, slp, pce, pcr, rej, v, fact, fint;
  seqrb_req_s  req;
  seqrb_stat_s stat;
  seqrb_nvm_s  nvm;
  logic [7:0]  rdat, vset, f1, f2, close, open, vflags, ctl2, d, gp, deb, lp;
  logic [6:0]  locks;
  logic [1:0]  pdmd, shdn;
  int          mismatches, cmp_count, cyc;

  // Device under test
  seqrb_bank u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req), .rd_data_out(rdat),
    .rd_valid_out(rval), .wr_refused_out(refused), .stat_in(stat), .fault1_set_in(f1),
    .fault2_set_in(f2), .vendor_set_in(vset), .wdt_force_in(wforce), .wdt_pdmd_in(pdmd),
    .pseq_force_act_in(pforce), .nvm_in(nvm), .nvm_load_in(nload), .general_output_levels_out(gp),
    .debounce_out(deb), .long_press_out(lp), .forced_shutdown_code_out(shdn), .force_act_out(fact),
    .force_int_out(fint), .ctl2_out(ctl2), .packet_check_enable_out(pce),
    .packet_check_required_out(pcr), .reject_missing_pec_out(rej),
    .watchdog_sleep_disable_out(slp), .wdt_close_out(close), .wdt_open_out(open),
    .locks_out(locks), .vendor_flags_out(vflags));

  // Host side
  seqrb_host u_host (.clk_in(clk_in), .rd_data_in(rdat), .rd_valid_in(rval), .req_out(req));

  // Clock generator
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  task automatic summarize;
    $display("mismatches %0d cmp_count %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // Read one register and compare it
  task automatic rd_chk(input logic [7:0] a, exp, input string m);
    u_host.rd(a, d, v);
    chk(d, exp, m);
  endtask : rd_chk

  // Reset held for four cycles
  task automatic do_reset;
    rst_n_in = 1'b0;
    repeat (4) @(negedge clk_in);
    rst_n_in = 1'b1;
  endtask : do_reset

  task automatic t_reset;
    chk({1'b0, locks}, 8'h00, "locks rst");
    chk(vflags, 8'h00, "vendor rst");
    u_host.rd(ADDR_CONTROL_STATUS, d, v);
    chk(d, 8'hA5, "status rd");
    chk({7'h00, v}, 8'h01, "rd valid");
    u_host.rd(8'h05, d, v);
    chk(d, 8'h00, "unmapped rd");
  endtask : t_reset

  // Image load fills read-only and loadable registers, masks applied
  task automatic t_nvm;
    nvm = '{alt_en: 8'h11, alt_dir: 8'h22, pp_up: 8'h33, pp_lo: 8'h44, clk_cfg: 8'h55, general_output_levels: 8'hFF,
            debounce: 8'hFF, long_prs: 8'h66, ctl1: 8'hF0, ctl2: 8'h03, wdt_cfg: 8'hFF, wdt_close: 8'h77,
            wdt_open: 8'h88};
    @(negedge clk_in);
    nload = 1'b1;
    @(negedge clk_in);
    nload = 1'b0;
    rd_chk(ADDR_ALT_EN, 8'h11, "alt en");
    rd_chk(ADDR_ALT_DIR, 8'h22, "alt dir");
    rd_chk(ADDR_PP_UP, 8'h33, "pp up");
    rd_chk(ADDR_PP_LO, 8'h44, "pp lo");
    rd_chk(ADDR_CLK_CFG, 8'h55, "clk cfg");
    chk(gp, MASK_GENERAL_OUTPUT_LEVELS, "gp load");
    chk(deb, MASK_DEBOUNCE, "deb load");
    chk(lp, 8'h66, "lp load");
    chk({7'h00, slp}, 8'h01, "sleep load");
    chk(close, 8'h77, "close load");
    chk(open, 8'h88, "open load");
    chk({7'h00, rej}, 8'h01, "pec load");
    u_host.wr(ADDR_ALT_EN, 8'h00);
    rd_chk(ADDR_ALT_EN, 8'h11, "ro write ignored");
    // Load and host write in one cycle: the image wins
    fork
      u_host.wr(ADDR_GENERAL_OUTPUT_LEVELS, 8'h05);
      begin
        @(negedge clk_in);
        nload = 1'b1;
        @(negedge clk_in);
        nload = 1'b0;
      end
    join
    chk(gp, MASK_GENERAL_OUTPUT_LEVELS, "load beats write");
    u_host.wr(ADDR_GENERAL_OUTPUT_LEVELS, 8'hF5);
    chk(gp, 8'h05, "gp masked");
  endtask : t_nvm

  task automatic t_wdt;
    u_host.wr(ADDR_WDT_CFG, 8'h01);
    chk({7'h00, slp}, 8'h01, "sleep dis on");
    u_host.wr(ADDR_WDT_CFG, 8'h00);
    chk({7'h00, slp}, 8'h00, "sleep dis off");
    u_host.wr(ADDR_WDT_CLOSE, 8'hFF);
    chk(close, 8'hFF, "close");
    u_host.wr(ADDR_WDT_OPEN, 8'h01);
    chk(open, 8'h01, "open");
    u_host.rd(ADDR_WDT_CLOSE, d, v);
    chk(d, 8'hFF, "close rd");
  endtask : t_wdt

  task automatic t_w1c;
    @(negedge clk_in);
    vset = 8'h81;
    f1 = 8'h10;
    f2 = 8'h02;
    @(negedge clk_in);
    {vset, f1, f2} = '0;
    chk(vflags, 8'h81, "vendor set");
    rd_chk(ADDR_FAULT1, 8'h10, "fault1 set");
    rd_chk(ADDR_FAULT2, 8'h02, "fault2 set");
    u_host.wr(ADDR_FAULT1, 8'h10);
    rd_chk(ADDR_FAULT1, 8'h00, "fault1 w1c");
    u_host.wr(ADDR_VENDOR, 8'h01);
    u_host.rd(ADDR_VENDOR, d, v);
    chk(d, 8'h80, "vendor w1c");
    // Event and clear in one cycle: the event must survive
    fork
      u_host.wr(ADDR_VENDOR, 8'h80);
      begin
        @(negedge clk_in);
        vset = 8'h80;
        @(negedge clk_in);
        vset = 8'h00;
      end
    join
    chk(vflags, 8'h80, "vendor set wins");
    u_host.wr(ADDR_VENDOR, 8'h80);
    chk(vflags, 8'h00, "vendor cleared");
  endtask : t_w1c

  task automatic t_ctl;
    @(negedge clk_in);
    pforce = 1'b1;
    @(negedge clk_in);
    pforce = 1'b0;
    chk({7'h00, fact}, 8'h01, "fact set by engine");
    u_host.wr(ADDR_CTL1, 8'h0C);
    rd_chk(ADDR_CTL1, 8'h0C, "fact kept fint set");
    u_host.wr(ADDR_CTL1, 8'h03);
    chk({6'h00, shdn}, 8'h03, "shdn host");
    chk({6'h00, fint, fact}, 8'h00, "fact fint cleared");
    @(negedge clk_in);
    pdmd = 2'h1;
    wforce = 1'b1;
    @(negedge clk_in);
    wforce = 1'b0;
    chk({6'h00, shdn}, 8'h01, "shdn wdt");
    u_host.wr(ADDR_CTL2, 8'h03);
    chk({7'h00, rej}, 8'h01, "pec req");
    chk({6'h00, pcr, pce}, 8'h03, "pec bits");
    u_host.wr(ADDR_CTL2, 8'h02);
    chk({7'h00, rej}, 8'h00, "pec off");
    u_host.wr(ADDR_CTL2, 8'h01);
    chk({7'h00, rej}, 8'h00, "pec opt");
  endtask : t_ctl

  // Lock one group, then try to write it; refusal must leave value intact
  task automatic lock_try(input logic [7:0] lk, a, dat, exp);
    u_host.wr(ADDR_PROT, lk);
    chk({7'h00, refused}, 8'h00, "prot not refused");
    u_host.wr(a, dat);
    chk({7'h00, refused}, 8'h01, "refused");
    u_host.rd(a, d, v);
    chk(d, exp, "locked value kept");
  endtask : lock_try

  task automatic t_locks;
    lock_try(8'h10, ADDR_WDT_CLOSE, 8'h12, 8'hFF);
    chk(close, 8'hFF, "wdt locked");
    lock_try(8'h01, ADDR_CTL1, 8'h00, 8'h01);
    chk({6'h00, shdn}, 8'h01, "wrk locked");
    lock_try(8'h01, ADDR_GENERAL_OUTPUT_LEVELS, 8'h0A, 8'h05);
    chk(gp, 8'h05, "gp locked");
    lock_try(8'h40, ADDR_CTL2, 8'h00, 8'h01);
    chk(ctl2, 8'h01, "ctl locked");
    lock_try(8'h40, ADDR_LONG_PRS, 8'h00, 8'h66);
    chk(lp, 8'h66, "lp locked");
    u_host.wr(ADDR_PROT, 8'h2E);
    chk({1'b0, locks}, 8'h7F, "seq locks");
    u_host.wr(ADDR_PROT, 8'h00);
    chk({1'b0, locks}, 8'h7F, "lock sticky");
    do_reset();
    chk({1'b0, locks}, 8'h00, "lock cleared");
    chk(close, 8'h00, "close rst");
    u_host.wr(ADDR_WDT_CLOSE, 8'h40);
    chk(close, 8'h40, "unlocked after reset");
  endtask : t_locks

  // Hang guard
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      mismatches++;
      summarize();
    end
  end

  initial
  begin
    {rst_n_in, wforce, pforce, nload, pdmd, vset, f1, f2} = '0;
    stat = '0;
    stat.control_status = 8'hA5;
    nvm = '0;
    do_reset();
    t_reset();
    t_nvm();
    t_wdt();
    t_w1c();
    t_ctl();
    t_locks();
    summarize();
  end
endmodule : testbench
